// File: hdl/sfx_pkg.sv
// Shared constants, register map and types for sensor frame and exposure control
package sfx_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DW = 16;
    localparam int unsigned AW = 8;
    // Register map
    localparam logic [AW-1:0] ADR_HBLANK_B = 8'h05;
    localparam logic [AW-1:0] ADR_VBLANK_B = 8'h06;
    localparam logic [AW-1:0] ADR_HBLANK_A = 8'h07;
    localparam logic [AW-1:0] ADR_VBLANK_A = 8'h08;
    localparam logic [AW-1:0] ADR_SHUT_WIDTH = 8'h09;
    localparam logic [AW-1:0] ADR_SHUT_DELAY = 8'h0c;
    localparam logic [AW-1:0] ADR_RESTART = 8'h0d;
    localparam logic [AW-1:0] ADR_FV_ADJUST = 8'h1f;
    localparam logic [AW-1:0] ADR_RMODE_B = 8'h20;
    localparam logic [AW-1:0] ADR_RMODE_A = 8'h21;
    localparam logic [AW-1:0] ADR_FLASH = 8'h23;
    localparam logic [AW-1:0] ADR_OUT_FMT = 8'h25;
    localparam logic [AW-1:0] ADR_CONTEXT = 8'hf2;
    // Host-side command port registers
    localparam logic [AW-1:0] HADR_CMD_ADDR = 8'h00;
    localparam logic [AW-1:0] HADR_CMD_DATA = 8'h01;
    localparam logic [AW-1:0] HADR_CMD_GO = 8'h02;
    localparam logic [AW-1:0] HADR_STATUS = 8'h03;
    localparam logic [AW-1:0] HADR_RDATA = 8'h04;
    localparam logic [AW-1:0] HADR_FRAMES = 8'h05;
    // Reset values
    localparam logic [DW-1:0] RST_CONTEXT = 16'h000b;
    localparam logic [DW-1:0] RST_HBLANK_B = 16'h015c;
    localparam logic [DW-1:0] RST_VBLANK_B = 16'h0020;
    localparam logic [DW-1:0] RST_RMODE_B = 16'h0000;
    localparam logic [DW-1:0] RST_HBLANK_A = 16'h00ae;
    localparam logic [DW-1:0] RST_VBLANK_A = 16'h0010;
    localparam logic [DW-1:0] RST_RMODE_A = 16'h0490;
    localparam logic [DW-1:0] RST_SHUT_WIDTH = 16'h04d0;
    localparam logic [DW-1:0] RST_FLASH = 16'h0000;
    // Field positions
    localparam int unsigned CTX_BLANK_BIT = 0;
    localparam int unsigned CTX_RMODE_BIT = 1;
    localparam int unsigned CTX_FMT_BIT = 3;
    localparam int unsigned CTX_RESTART_BIT = 9;
    localparam int unsigned CTX_FLASH_BIT = 8;
    localparam int unsigned RST_RESTART_BIT = 1;
    localparam int unsigned RM_BIN_BIT = 15;
    localparam int unsigned RM_ONE_ADC_BIT = 10;
    localparam int unsigned RM_ROW_SKIP_EN = 4;
    localparam int unsigned RM_COL_SKIP_EN = 7;
    localparam int unsigned RM_COL_SKIP_LO = 5;
    localparam int unsigned FMT_LO = 14;
    localparam int unsigned FV_RISE_EN = 7;
    localparam int unsigned FV_FALL_EN = 15;
    localparam int unsigned FV_FALL_LO = 8;
    localparam int unsigned FL_ENABLE = 8;
    localparam int unsigned FL_XENON = 9;
    localparam int unsigned FL_ONCE = 10;
    localparam int unsigned FL_DLY_LO = 11;
    localparam int unsigned FL_GOOD = 14;
    // Timing in master clocks
    localparam logic [15:0] OVH_TWO_ADC = 16'd260;
    localparam logic [15:0] OVH_ONE_ADC = 16'd262;
    typedef enum logic [1:0] {SFX_FMT_NORMAL = 2'h0, SFX_FMT_CONT = 2'h1, SFX_FMT_XOR = 2'h2} sfx_fmt_e;
    typedef enum logic [1:0] {SFX_H_IDLE = 2'h0, SFX_H_WRITE = 2'h1, SFX_H_READ = 2'h3} sfx_host_e;
    // Effective skip shift: column skip field plus one when skip is enabled, plus one level for binning
    function automatic logic [2:0] sfx_skip_shift(input logic [DW-1:0] rm);
        logic [2:0] s;
        s = 3'h0;
        if (rm[RM_COL_SKIP_EN]) s = 3'(rm[RM_COL_SKIP_LO +: 2]) + 3'h1;
        if (rm[RM_BIN_BIT]) s = s + 3'h1;
        return s;
    endfunction
endpackage

// File: hdl/sfx_link_if.sv
// Link between sensor timing block and host controller
`timescale 1ns/100ps
`default_nettype none
interface sfx_link_if;
    logic [7:0] cfg_addr;
    logic [15:0] cfg_wdata;
    logic cfg_wr;
    logic cfg_rd;
    logic [15:0] cfg_rdata;
    logic frame_valid;
    logic line_valid;
    logic flash;
    logic pix_tick;
    modport sensor (input cfg_addr, input cfg_wdata, input cfg_wr, input cfg_rd, output cfg_rdata,
        output frame_valid, output line_valid, output flash, output pix_tick);
    modport host (output cfg_addr, output cfg_wdata, output cfg_wr, output cfg_rd, input cfg_rdata,
        input frame_valid, input line_valid, input flash, input pix_tick);
endinterface
`default_nettype wire

// File: hdl/sfx_sensor.sv
// Sensor end: context registers, frame timing, exposure and flash control
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RL1] Context bits 0,1,3 select A or B copies; bit 3 is unused here, the format register is shared
// [RL2] Any combination of select bits accepted
// [RL3] Context register resets to 0x000B
// [RL4] Context B defaults 0x015C, 0x0020, 0x0000
// [RL5] Context A defaults 0x00AE, 0x0010, 0x0490
// [RL6] Read mode taken from selected context
// [RL7] Context register carries flash and restart bits
// [RL8] Bits 14-15 select row-valid format
// [RL9] Last format: row-valid XOR frame-valid
// [RL10] Early frame-valid rise N+1 rows
// [RL11] Early frame-valid fall M+1 rows
// [RL12] Host keeps M below row width
// [RL13] Integration from shutter width minus delay
// [RL14] Overhead 260 clocks, 262 single converter
// [RL15] Binning doubles effective skip factor
// [RL16] Long shutter width adds blanking rows
// [RL17] Host bounds shutter delay by row time
// [RL18] Flash: single fire, frame delay, xenon pulse
// [RL19] Restart bit restarts and masks bad frame
// [RL20] Status bit 14 marks correctly flashed frames
// [RL21] Host avoids bad xenon exposure settings
// [RL22] Host picks flicker-free integration times
// [RL23] Binning bit 15 of active read mode
// [RL24] Context change applies at frame boundary
module sfx_sensor
    import sfx_pkg::*;
#(
    parameter int unsigned COLS = 1600,
    parameter int unsigned ROWS = 1200,
    parameter int unsigned EDGE_MARGIN_COLUMNS = 4
) (
    input wire logic clk,
    input wire logic rst,
    sfx_link_if.sensor link,
    output logic integrate_start,
    output logic [31:0] exposure_duration
);
    logic [DW-1:0] ctx_ff, hb_b_ff, vb_b_ff, hb_a_ff, vb_a_ff, sw_ff, sd_ff, rc_ff, fva_ff;
    logic [DW-1:0] rm_b_ff, rm_a_ff, fl_ff, fmt_ff;
    logic [3:0] act_ctx_ff;
    logic [DW-1:0] rdata_ff;
    logic restart_req;
    logic [DW-1:0] col_ff, row_ff;
    logic fv_ff, lv_cont_ff, flash_ff, good_ff, masked_ff;
    logic [2:0] fl_wait_ff;
    logic [DW-1:0] fl_pulse_ff;
    logic fired_ff;
    logic [DW-1:0] hb, vb, rm, width, frame_rows, rows_total, nxt_col, nxt_row;
    logic [2:0] sh;
    logic row_end, frame_end, in_active_row, fv_raw, rise_ok, fall_ok;
    logic [6:0] n_rise, m_fall;
    logic [15:0] ovh;
    logic [31:0] row_time;

    // Register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctx_ff <= RST_CONTEXT; // see [RL3]
            hb_b_ff <= RST_HBLANK_B; // see [RL4]
            vb_b_ff <= RST_VBLANK_B;
            rm_b_ff <= RST_RMODE_B;
            hb_a_ff <= RST_HBLANK_A; // see [RL5]
            vb_a_ff <= RST_VBLANK_A;
            rm_a_ff <= RST_RMODE_A;
            sw_ff <= RST_SHUT_WIDTH;
            sd_ff <= '0;
            rc_ff <= '0;
            fva_ff <= '0;
            fl_ff <= RST_FLASH;
            fmt_ff <= '0;
        end else begin
            rc_ff[RST_RESTART_BIT] <= 1'b0;
            ctx_ff[CTX_RESTART_BIT] <= 1'b0;
            if (link.cfg_wr) begin
                case (link.cfg_addr)
                    ADR_HBLANK_B: hb_b_ff <= link.cfg_wdata;
                    ADR_VBLANK_B: vb_b_ff <= link.cfg_wdata;
                    ADR_HBLANK_A: hb_a_ff <= link.cfg_wdata;
                    ADR_VBLANK_A: vb_a_ff <= link.cfg_wdata;
                    ADR_SHUT_WIDTH: sw_ff <= link.cfg_wdata;
                    ADR_SHUT_DELAY: sd_ff <= link.cfg_wdata;
                    ADR_RESTART: rc_ff <= link.cfg_wdata;
                    ADR_FV_ADJUST: fva_ff <= link.cfg_wdata;
                    ADR_RMODE_B: rm_b_ff <= link.cfg_wdata;
                    ADR_RMODE_A: rm_a_ff <= link.cfg_wdata;
                    ADR_OUT_FMT: fmt_ff <= link.cfg_wdata;
                    ADR_CONTEXT: ctx_ff <= link.cfg_wdata; // see [RL2]
                    default: ;
                endcase
            end
            // Flash enable may also come through the context register
            if (link.cfg_wr && link.cfg_addr == ADR_FLASH)
                fl_ff <= link.cfg_wdata;
            else if (link.cfg_wr && link.cfg_addr == ADR_CONTEXT)
                fl_ff[FL_ENABLE] <= link.cfg_wdata[CTX_FLASH_BIT]; // see [RL7]
        end
    end

    assign restart_req = rc_ff[RST_RESTART_BIT] | ctx_ff[CTX_RESTART_BIT]; // see [RL19] [RL7]

    // Read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (link.cfg_rd) begin
            case (link.cfg_addr)
                ADR_HBLANK_B: rdata_ff <= hb_b_ff;
                ADR_VBLANK_B: rdata_ff <= vb_b_ff;
                ADR_HBLANK_A: rdata_ff <= hb_a_ff;
                ADR_VBLANK_A: rdata_ff <= vb_a_ff;
                ADR_SHUT_WIDTH: rdata_ff <= sw_ff;
                ADR_SHUT_DELAY: rdata_ff <= sd_ff;
                ADR_RESTART: rdata_ff <= rc_ff;
                ADR_FV_ADJUST: rdata_ff <= fva_ff;
                ADR_RMODE_B: rdata_ff <= rm_b_ff;
                ADR_RMODE_A: rdata_ff <= rm_a_ff;
                ADR_FLASH: rdata_ff <= {fl_ff[15], good_ff, fl_ff[13:0]}; // see [RL20]
                ADR_OUT_FMT: rdata_ff <= fmt_ff;
                ADR_CONTEXT: rdata_ff <= ctx_ff;
                default: rdata_ff <= '0;
            endcase
        end
    end
    assign link.cfg_rdata = rdata_ff;

    // Selection latched at frame boundary so no frame mixes contexts
    always_ff @(posedge clk) begin
        if (rst) act_ctx_ff <= RST_CONTEXT[3:0];
        else if (frame_end || restart_req) act_ctx_ff <= ctx_ff[3:0]; // see [RL24]
    end

    // Each group chooses its copy independently
    assign hb = act_ctx_ff[CTX_BLANK_BIT] ? hb_b_ff : hb_a_ff; // see [RL1]
    assign vb = act_ctx_ff[CTX_BLANK_BIT] ? vb_b_ff : vb_a_ff;
    assign rm = act_ctx_ff[CTX_RMODE_BIT] ? rm_b_ff : rm_a_ff; // see [RL6] [RL23]
    assign sh = sfx_skip_shift(rm); // see [RL15]
    assign width = DW'(COLS >> sh) + DW'(EDGE_MARGIN_COLUMNS);
    assign frame_rows = DW'((rm[RM_ROW_SKIP_EN] || rm[RM_BIN_BIT]) ? (ROWS >> sh) : ROWS);
    assign rows_total = (sw_ff > frame_rows + vb) ? sw_ff : frame_rows + vb; // see [RL16]

    // Counters tick once per master clock, one pixel per clock
    assign row_end = (col_ff == width + hb - 16'h0001);
    assign frame_end = row_end && (row_ff == rows_total - 16'h0001);
    assign nxt_col = row_end ? '0 : col_ff + 16'h0001;
    assign nxt_row = row_end ? (frame_end ? '0 : row_ff + 16'h0001) : row_ff;
    always_ff @(posedge clk) begin
        if (rst || restart_req) begin
            col_ff <= '0;
            row_ff <= '0;
        end else begin
            col_ff <= nxt_col;
            row_ff <= nxt_row;
        end
    end

    assign in_active_row = (row_ff < frame_rows);
    assign n_rise = fva_ff[6:0];
    assign m_fall = fva_ff[FV_FALL_LO +: 7];
    // Judged on the next row so frame-valid lines up with the counters, like lv_cont_ff
    // Early rise: start N+1 rows before first active row, measured from end of frame
    assign rise_ok = fva_ff[FV_RISE_EN] && (nxt_row >= rows_total - 16'(n_rise) - 16'h0001); // see [RL10]
    // Early fall: drop M+1 rows before last active row ends; host keeps M small
    assign fall_ok = fva_ff[FV_FALL_EN] && (nxt_row + 16'(m_fall) + 16'h0001 >= frame_rows); // see [RL11] [RL12]
    assign fv_raw = ((nxt_row < frame_rows) && !fall_ok) || rise_ok;

    always_ff @(posedge clk) begin
        if (rst || restart_req) begin
            fv_ff <= 1'b0;
            lv_cont_ff <= 1'b0;
        end else begin
            // Mask ends with the masked frame, not one cycle into the next
            fv_ff <= fv_raw && (!masked_ff || frame_end);
            lv_cont_ff <= (nxt_col < width);
        end
    end

    // Row-valid output format; format bits come from the single ADR_OUT_FMT register, not a context bit 3 group
    always_comb begin
        case (sfx_fmt_e'(fmt_ff[FMT_LO +: 2])) // see [RL8]
            SFX_FMT_NORMAL: link.line_valid = lv_cont_ff && fv_ff && in_active_row;
            SFX_FMT_CONT: link.line_valid = lv_cont_ff;
            SFX_FMT_XOR: link.line_valid = lv_cont_ff ^ fv_ff; // see [RL9]
            default: link.line_valid = lv_cont_ff && fv_ff && in_active_row;
        endcase
    end
    assign link.frame_valid = fv_ff;
    assign link.pix_tick = 1'b1;

    // Integration time in master clocks
    assign ovh = rm[RM_ONE_ADC_BIT] ? OVH_ONE_ADC : OVH_TWO_ADC; // see [RL14]
    assign row_time = 32'(width) + 32'(hb);
    always_ff @(posedge clk) begin
        if (rst) exposure_duration <= '0;
        else exposure_duration <= 32'(sw_ff) * row_time - 32'(ovh) - 32'(sd_ff); // see [RL13] [RL17]
    end
    always_ff @(posedge clk) begin
        if (rst) integrate_start <= 1'b0;
        else integrate_start <= frame_end;
    end

    // Flash sequencing: delay in frames, single fire, xenon pulse length in rows
    always_ff @(posedge clk) begin
        if (rst || !fl_ff[FL_ENABLE]) begin
            fl_wait_ff <= '0;
            flash_ff <= 1'b0;
            fl_pulse_ff <= '0;
            fired_ff <= 1'b0;
            good_ff <= 1'b0;
        end else if (frame_end) begin
            if (fl_wait_ff != fl_ff[FL_DLY_LO +: 3]) begin
                fl_wait_ff <= fl_wait_ff + 3'h1; // see [RL18]
            end else if (!(fl_ff[FL_ONCE] && fired_ff)) begin
                flash_ff <= 1'b1;
                fired_ff <= 1'b1;
                fl_pulse_ff <= {8'h00, fl_ff[7:0]};
                // A frame is good once an LED flash covered its whole integration; with xenon set it is never marked good
                good_ff <= flash_ff && !fl_ff[FL_XENON]; // see [RL20]
            end else begin
                flash_ff <= 1'b0;
                good_ff <= fl_ff[FL_XENON] ? 1'b0 : flash_ff;
            end
        end else if (fl_ff[FL_XENON] && flash_ff && row_end) begin
            if (fl_pulse_ff == '0) flash_ff <= 1'b0;
            else fl_pulse_ff <= fl_pulse_ff - 16'h0001;
        end
    end
    assign link.flash = flash_ff;

    // Restart masks the first partly lit frame
    always_ff @(posedge clk) begin
        if (rst) masked_ff <= 1'b0;
        else if (restart_req) masked_ff <= 1'b1; // see [RL19]
        else if (frame_end) masked_ff <= 1'b0;
    end
endmodule
`default_nettype wire

// File: hdl/sfx_host.sv
// Host end: register-port command master and frame monitor
`timescale 1ns/100ps
`default_nettype none
module sfx_host
    import sfx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sfx_link_if.host link,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata
);
    logic [AW-1:0] cmd_addr_ff;
    logic [DW-1:0] cmd_data_ff, rdata_ff, sens_rd_ff, frames_ff;
    logic busy_ff, fv_d_ff;
    sfx_host_e st_ff;

    // Command registers; bit 0 of the go write selects read
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_addr_ff <= '0;
            cmd_data_ff <= '0;
        end else if (wr) begin
            if (addr == HADR_CMD_ADDR) cmd_addr_ff <= wdata[AW-1:0];
            if (addr == HADR_CMD_DATA) cmd_data_ff <= wdata;
        end
    end

    // Host forwards settings without checks; legal values are left to the caller: see [RL12] [RL17] [RL21] [RL22]
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= SFX_H_IDLE;
            busy_ff <= 1'b0;
            sens_rd_ff <= '0;
        end else begin
            case (st_ff)
                SFX_H_IDLE: if (wr && addr == HADR_CMD_GO && !busy_ff) begin
                    st_ff <= wdata[0] ? SFX_H_READ : SFX_H_WRITE;
                    busy_ff <= 1'b1;
                end
                SFX_H_WRITE: begin
                    st_ff <= SFX_H_IDLE;
                    busy_ff <= 1'b0;
                end
                SFX_H_READ: st_ff <= SFX_H_IDLE;
                default: st_ff <= SFX_H_IDLE;
            endcase
            // Sensor read data lands one cycle after the strobe
            if (busy_ff && st_ff == SFX_H_IDLE) begin
                sens_rd_ff <= link.cfg_rdata;
                busy_ff <= 1'b0;
            end
        end
    end
    assign link.cfg_addr = cmd_addr_ff;
    assign link.cfg_wdata = cmd_data_ff;
    assign link.cfg_wr = (st_ff == SFX_H_WRITE);
    assign link.cfg_rd = (st_ff == SFX_H_READ);

    // Count frames at frame-valid fall
    always_ff @(posedge clk) begin
        if (rst) begin
            fv_d_ff <= 1'b0;
            frames_ff <= '0;
        end else begin
            fv_d_ff <= link.frame_valid;
            if (fv_d_ff && !link.frame_valid) frames_ff <= frames_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) rdata_ff <= '0;
        else if (rd) begin
            case (addr)
                HADR_CMD_ADDR: rdata_ff <= {8'h00, cmd_addr_ff};
                HADR_CMD_DATA: rdata_ff <= cmd_data_ff;
                HADR_STATUS: rdata_ff <= {12'h000, link.flash, link.line_valid, link.frame_valid, busy_ff};
                HADR_RDATA: rdata_ff <= sens_rd_ff;
                HADR_FRAMES: rdata_ff <= frames_ff;
                default: rdata_ff <= '0;
            endcase
        end
    end
    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// File: bench/sfx_link_chk.sv
// Concurrent checks on the link between sensor and host ends
`timescale 1ns/100ps
`default_nettype none
module sfx_link_chk
    import sfx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [15:0] cfg_rdata,
    input wire logic frame_valid,
    input wire logic line_valid,
    input wire logic flash,
    input wire logic pix_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [255:0] seen_ff;
    logic [15:0] shadow_ff [0:255];
    logic flash_ever_ff;
    logic [15:0] exp_ff;
    logic rb_ff;
    logic rv_ff;
    logic [16:0] rv_w;
    function automatic logic is_rw(input logic [7:0] a);
        return a inside {ADR_HBLANK_B, ADR_VBLANK_B, ADR_HBLANK_A, ADR_VBLANK_A, ADR_SHUT_WIDTH,
            ADR_SHUT_DELAY, ADR_FV_ADJUST, ADR_RMODE_B, ADR_RMODE_A, ADR_OUT_FMT};
    endfunction
    function automatic logic is_mapped(input logic [7:0] a);
        return is_rw(a) || (a inside {ADR_RESTART, ADR_FLASH, ADR_CONTEXT});
    endfunction
    function automatic logic [16:0] rst_val(input logic [7:0] a);
        case (a)
            ADR_HBLANK_B: return {1'b1, RST_HBLANK_B};
            ADR_VBLANK_B: return {1'b1, RST_VBLANK_B};
            ADR_HBLANK_A: return {1'b1, RST_HBLANK_A};
            ADR_VBLANK_A: return {1'b1, RST_VBLANK_A};
            ADR_RMODE_B: return {1'b1, RST_RMODE_B};
            ADR_RMODE_A: return {1'b1, RST_RMODE_A};
            ADR_CONTEXT: return {1'b1, RST_CONTEXT};
            default: return 17'h00000;
        endcase
    endfunction
    always_ff @(posedge clk) begin
        if (rst) begin
            seen_ff <= '0;
        end else if (cfg_wr) begin
            seen_ff[cfg_addr] <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (cfg_wr) begin
            shadow_ff[cfg_addr] <= cfg_wdata;
        end
    end
    // Flash never armed means no pulse and no good-frame flag may appear
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_ever_ff <= 1'b0;
        end else if (cfg_wr && ((cfg_addr == ADR_FLASH && cfg_wdata[FL_ENABLE])
            || (cfg_addr == ADR_CONTEXT && cfg_wdata[CTX_FLASH_BIT]))) begin
            flash_ever_ff <= 1'b1;
        end
    end
    assign rv_w = rst_val(cfg_addr);
    always_ff @(posedge clk) begin
        rb_ff <= !rst && cfg_rd && seen_ff[cfg_addr] && is_rw(cfg_addr);
        rv_ff <= !rst && cfg_rd && !seen_ff[cfg_addr] && rv_w[16];
        exp_ff <= seen_ff[cfg_addr] ? shadow_ff[cfg_addr] : rv_w[15:0];
    end
    AST_RESET_VALUE: assert property (rv_ff |-> cfg_rdata == exp_ff)
        else $error("register read differs from its reset value");
    AST_READBACK: assert property (rb_ff |-> cfg_rdata == exp_ff)
        else $error("register read differs from last write");
    AST_UNMAPPED: assert property (cfg_rd && !is_mapped(cfg_addr) |=> cfg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero");
    AST_RESTART_CLEAR: assert property (cfg_rd && cfg_addr == ADR_RESTART
        |=> !cfg_rdata[RST_RESTART_BIT])
        else $error("restart bit did not clear");
    AST_CTX_RESTART_CLEAR: assert property (cfg_rd && cfg_addr == ADR_CONTEXT
        |=> !cfg_rdata[CTX_RESTART_BIT])
        else $error("context restart bit did not clear");
    AST_GOOD_NO_FLASH: assert property (!flash_ever_ff && cfg_rd && cfg_addr == ADR_FLASH
        |=> !cfg_rdata[FL_GOOD])
        else $error("good-frame flag set without flash");
    AST_FLASH_IDLE: assert property (!flash_ever_ff |-> !flash)
        else $error("flash pulse without flash enable");
    AST_WR_PULSE: assert property (cfg_wr |=> !cfg_wr && !cfg_rd)
        else $error("write strobe longer than one cycle");
    AST_RD_PULSE: assert property (cfg_rd |=> !cfg_rd && !cfg_wr)
        else $error("read strobe longer than one cycle");
    AST_PIX_TICK: assert property (pix_tick)
        else $error("pixel tick low");
endmodule
`default_nettype wire

// File: bench/sensor_frame_exposure_control_test.sv
// Testbench joining sensor and host ends over the link
`timescale 1ns/100ps
`default_nettype none
module sensor_frame_exposure_control_test
    import sfx_pkg::*;
;
    localparam int ROW = 20 + 16;
    localparam logic [7:0] RA [7] = '{ADR_HBLANK_B, ADR_VBLANK_B, ADR_HBLANK_A, ADR_VBLANK_A,
        ADR_RMODE_B, ADR_RMODE_A, ADR_CONTEXT};
    localparam logic [15:0] RV [7] = '{RST_HBLANK_B, RST_VBLANK_B, RST_HBLANK_A, RST_VBLANK_A,
        RST_RMODE_B, RST_RMODE_A, RST_CONTEXT};
    // Short rows and few blank rows keep each frame near 432 clocks
    localparam logic [7:0] CA [7] = '{ADR_HBLANK_B, ADR_VBLANK_B, ADR_SHUT_WIDTH, ADR_SHUT_DELAY,
        ADR_FV_ADJUST, ADR_OUT_FMT, ADR_RMODE_B};
    localparam logic [15:0] CV [7] = '{16'h0010, 16'h0004, 16'h0008, 16'h0005, 16'h0000, 16'h0000, 16'h0000};
    logic clk;
    logic rst;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [DW-1:0] rdata;
    logic integrate_start;
    logic [31:0] exposure_duration;
    int bad_count = 0;
    int compares = 0;
    int fv_len, lv_in, lv_out, period, base, starts;
    logic [15:0] d;
    sfx_link_if link();
    sfx_sensor #(.COLS(16), .ROWS(8)) sfx_sensor_inst (.clk(clk), .rst(rst), .link(link.sensor),
        .integrate_start(integrate_start), .exposure_duration(exposure_duration));
    sfx_host sfx_host_inst (.clk(clk), .rst(rst), .link(link.host), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    sfx_link_chk sfx_link_chk_inst (.clk(clk), .rst(rst), .cfg_addr(link.cfg_addr),
        .cfg_wdata(link.cfg_wdata), .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd), .cfg_rdata(link.cfg_rdata),
        .frame_valid(link.frame_valid), .line_valid(link.line_valid), .flash(link.flash),
        .pix_tick(link.pix_tick));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic hw(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic hr(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic wait_idle();
        logic [15:0] s;
        s = 16'h0001;
        for (int i = 0; i < 40 && s[0] !== 1'b0; i++) hr(HADR_STATUS, s);
        if (s[0] !== 1'b0) begin
            bad_count++;
            conclude();
        end
    endtask
    task automatic sw(input logic [7:0] a, input logic [15:0] v);
        hw(HADR_CMD_ADDR, 16'(a));
        hw(HADR_CMD_DATA, v);
        hw(HADR_CMD_GO, 16'h0000);
        wait_idle();
    endtask
    task automatic sr(input logic [7:0] a, output logic [15:0] v);
        hw(HADR_CMD_ADDR, 16'(a));
        hw(HADR_CMD_GO, 16'h0001);
        wait_idle();
        hr(HADR_RDATA, v);
    endtask
    // Second frame after a change, so pending settings have landed
    task automatic meas();
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 9000 && link.frame_valid !== 1'b1; n++) tick();
            lv_in = 0;
            lv_out = 0;
            starts = 0;
            for (fv_len = 0; fv_len < 9000 && link.frame_valid === 1'b1; fv_len++) begin
                lv_in += (link.line_valid === 1'b1);
                starts += (integrate_start === 1'b1);
                tick();
            end
            for (period = fv_len; period < 9000 && link.frame_valid !== 1'b1; period++) begin
                lv_out += (link.line_valid === 1'b1);
                starts += (integrate_start === 1'b1);
                tick();
            end
            if (period >= 9000) begin
                bad_count++;
                conclude();
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            sr(RA[i], d);
            check(32'(d), 32'(RV[i]));
        end
        sr(8'h40, d);
        check(32'(d), 32'h0);
        sw(ADR_FLASH, 16'h4000);
        sr(ADR_FLASH, d);
        check(32'(d[FL_GOOD]), 32'h0);
        sw(ADR_RESTART, 16'h0002);
        sr(ADR_RESTART, d);
        check(32'(d[RST_RESTART_BIT]), 32'h0);
        sw(ADR_CONTEXT, 16'h020b);
        sr(ADR_CONTEXT, d);
        check(32'(d[CTX_RESTART_BIT]), 32'h0);
        $display("test reset and control bits done");
        for (int i = 0; i < 7; i++) sw(CA[i], CV[i]);
        for (int i = 0; i < 7; i++) begin
            sr(CA[i], d);
            check(32'(d), 32'(CV[i]));
        end
        $display("test readback done");
        meas();
        base = fv_len;
        check(32'(period), 32'(12 * ROW));
        check(32'(starts), 32'h1);
        check(32'(lv_in), 32'(8 * 20));
        check(32'(lv_out), 32'h0);
        for (int f = 1; f < 3; f++) begin
            sw(ADR_OUT_FMT, 16'(f) << FMT_LO);
            meas();
            check(32'(lv_in), 32'(f == 2 ? base - 160 : 160));
            check(32'(lv_out), 32'(4 * 20));
        end
        sw(ADR_OUT_FMT, 16'h0000);
        sw(ADR_FV_ADJUST, 16'h0081);
        meas();
        check(32'(fv_len), 32'(base + 2 * ROW));
        sw(ADR_FV_ADJUST, 16'h8100);
        meas();
        check(32'(fv_len), 32'(base - 2 * ROW));
        sw(ADR_FV_ADJUST, 16'h0000);
        $display("test frame formats done");
        check(exposure_duration, 32'(8 * ROW) - 32'(OVH_TWO_ADC) - 32'd5);
        sw(ADR_SHUT_WIDTH, 16'h0010);
        meas();
        check(32'(period), 32'(16 * ROW));
        check(exposure_duration, 32'(16 * ROW) - 32'(OVH_TWO_ADC) - 32'd5);
        sw(ADR_CONTEXT, 16'h0009);
        check(exposure_duration, 32'(16 * ROW) - 32'(OVH_TWO_ADC) - 32'd5);
        meas();
        check(exposure_duration, 32'(16 * 28) - 32'(OVH_ONE_ADC) - 32'd5);
        sw(ADR_RMODE_A, 16'h8490);
        meas();
        check(exposure_duration, 32'(16 * 24) - 32'(OVH_ONE_ADC) - 32'd5);
        // LED flash, no delay: lit from the next frame, good from the one after
        sw(ADR_FLASH, 16'h0100);
        meas();
        sr(ADR_FLASH, d);
        check(32'(d[FL_GOOD]), 32'h1);
        hr(HADR_STATUS, d);
        check(32'(d[3]), 32'h1);
        $display("test exposure and context done");
        conclude();
    end
endmodule
`default_nettype wire
